// *** uaf_core.sv ***
// Purpose: Queued asynchronous serial transceiver with register port
// Assumes: Single clock; serial input synchronised internally
// Notes: Registers are byte addressed, read data one cycle after strobe
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01 - Transmit queue eight bits by 32 entries
// R02 - Receive queue twelve bits by 32 entries
// R03 - Queues off act as one bottom entry
// R04 - Frame: start, data LSB first, parity, stops
// R05 - Maskable requests ORed onto one output
// R06 - Crossing signals pass through synchronisers
// R07 - Line configuration held as 30-bit word
// R08 - Divisor is 16 integer plus 6 fraction
// R09 - Software programs divisor with rounded fraction
// R10 - Tick is 16x baud, divided by 16
// R11 - Enabled with queued data, send until empty
// R12 - Busy until queue empty and stops sent
// R13 - Receiver takes majority of three samples
// R14 - Start bit checked low at eighth tick
// R15 - Data sampled every 16 ticks, then parity
// R16 - Stop must be high, else framing error
// R17 - Entry holds data, fe, pe, break, overrun
// R18 - Full queue: set overrun, drop character
// R19 - Overrun copied into next stored character
// R20 - Queues off: unread character causes overrun
// R21 - Queues off: write loads idle shifter directly
// R22 - Loopback routes serial output to receiver
// R23 - Five to eight data bits, one or two stops
// R24 - Reset empties queues, clears overrun, line high
module uaf_core #(
  parameter int DEPTH = uaf_pkg::Q_DEPTH
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic [uaf_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [uaf_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [uaf_pkg::DATA_W-1:0] RDATA_O,
  // Serial line
  input wire logic SERIAL_IN_I,
  output logic SERIAL_OUT_O,
  // Status
  output logic BUSY_O,
  output logic IRQ_O
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] CAP_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CAP_ONE = CW'(1);

  typedef struct packed {
    uaf_pkg::uaf_cfg_t cfg;
    uaf_pkg::uaf_ctrl_t ctrl;
    logic [uaf_pkg::IRQ_W-1:0] mask;
    logic [PW-1:0] tx_wp;
    logic [PW-1:0] tx_rp;
    logic [CW-1:0] tx_cnt;
    logic [PW-1:0] rx_wp;
    logic [PW-1:0] rx_rp;
    logic [CW-1:0] rx_cnt;
    uaf_pkg::uaf_tx_state_t tx_st;
    logic [uaf_pkg::SC_W-1:0] tx_sc;
    logic [2:0] tx_bits;
    logic [uaf_pkg::TX_W-1:0] tx_sh;
    logic tx_par;
    logic tx_out;
    uaf_pkg::uaf_rx_state_t rx_st;
    logic [uaf_pkg::SC_W-1:0] rx_sc;
    logic [2:0] rx_bits;
    logic [uaf_pkg::TX_W-1:0] rx_sh;
    logic rx_armed;
    logic rx_have;
    logic rx_sa;
    logic rx_sb;
    logic rx_zero;
    logic rx_pe;
    logic overrun;
    logic sync1;
    logic sync2;
    logic [uaf_pkg::DATA_W-1:0] rdata;
    logic rd_mem;
  } uaf_core_state_t;

  uaf_core_state_t st;
  uaf_core_state_t next_st;

  logic tick;
  logic [uaf_pkg::TX_W-1:0] tx_q;
  logic [uaf_pkg::RX_W-1:0] rx_q;
  logic tx_we;
  logic tx_re;
  logic rx_we;
  logic rx_re;
  uaf_pkg::uaf_rx_entry_t rx_wdata;
  logic [CW-1:0] cap;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic tx_on;
  logic rx_on;
  logic rx_line;
  logic busy;
  logic bit_end;
  logic maj;
  logic decide;
  logic rx_done;
  logic ovr_set;
  logic ovr_clr;
  logic [uaf_pkg::IRQ_W-1:0] raw;
  logic [uaf_pkg::STAT_W-1:0] stat;
  logic [uaf_pkg::TX_W-1:0] wmask;

  // Queue slot; with queues off only the bottom entry is used
  function automatic logic [PW-1:0] q_addr(input logic [PW-1:0] ptr,
                                           input logic fen);
    q_addr = fen ? ptr : '0;
  endfunction

  uaf_baud u_baud (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .en_i (st.ctrl.en | busy),
    .int_i (st.cfg.ibrd),
    .frac_i (st.cfg.fbrd),
    .tick_o (tick)
  ); // R08

  uaf_mem #(.W(uaf_pkg::TX_W), .DEPTH(DEPTH)) u_txq (
    .clk_i (CLK_I),
    .we_i (tx_we),
    .waddr_i (q_addr(st.tx_wp, st.cfg.lcr.fen)),
    .wdata_i (WDATA_I[uaf_pkg::TX_W-1:0]),
    .re_i (tx_re),
    .raddr_i (q_addr(st.tx_rp, st.cfg.lcr.fen)),
    .rdata_o (tx_q)
  ); // R01

  uaf_mem #(.W(uaf_pkg::RX_W), .DEPTH(DEPTH)) u_rxq (
    .clk_i (CLK_I),
    .we_i (rx_we),
    .waddr_i (q_addr(st.rx_wp, st.cfg.lcr.fen)),
    .wdata_i (rx_wdata),
    .re_i (rx_re),
    .raddr_i (q_addr(st.rx_rp, st.cfg.lcr.fen)),
    .rdata_o (rx_q)
  ); // R02

  always_comb begin
    next_st = st;
    tx_we = 1'b0;
    tx_re = 1'b0;
    rx_we = 1'b0;
    rx_re = 1'b0;
    rx_done = 1'b0;
    ovr_set = 1'b0;
    ovr_clr = 1'b0;
    rx_wdata = '0;
    cap = st.cfg.lcr.fen ? CAP_FULL : CAP_ONE; // R03 R20
    tx_full = st.tx_cnt >= cap;
    tx_empty = st.tx_cnt == '0;
    rx_full = st.rx_cnt >= cap;
    rx_empty = st.rx_cnt == '0;
    tx_on = st.ctrl.en & st.ctrl.txe;
    rx_on = st.ctrl.en & st.ctrl.rxe;
    busy = !tx_empty || st.tx_st != uaf_pkg::TX_IDLE; // R12
    wmask = uaf_pkg::word_mask(st.cfg.lcr.wlen);
    rx_line = st.ctrl.loopback_enable ? st.tx_out : st.sync2; // R22
    bit_end = tick && st.tx_sc == uaf_pkg::TICK_LAST; // R10
    maj = (st.rx_sa & st.rx_sb) | (st.rx_sa & rx_line)
        | (st.rx_sb & rx_line); // R13
    decide = tick && st.rx_have && st.rx_sc == uaf_pkg::SMP_C;
    raw[uaf_pkg::IRQ_RX] = !rx_empty;
    raw[uaf_pkg::IRQ_TX] = !tx_full;
    raw[uaf_pkg::IRQ_OVR] = st.overrun;
    stat = '0;
    stat[uaf_pkg::ST_BUSY] = busy;
    stat[uaf_pkg::ST_RXE] = rx_empty;
    stat[uaf_pkg::ST_RXF] = rx_full;
    stat[uaf_pkg::ST_TXE] = tx_empty;
    stat[uaf_pkg::ST_TXF] = tx_full;
    stat[uaf_pkg::ST_OVR] = st.overrun;
    next_st.sync1 = SERIAL_IN_I;
    next_st.sync2 = st.sync1; // R06

    // Register writes
    if (WR_I) begin
      case (ADDR_I)
        uaf_pkg::A_DATA: begin
          if (!st.cfg.lcr.fen && tx_on && tx_empty &&
              st.tx_st == uaf_pkg::TX_IDLE) begin
            next_st.tx_sh = WDATA_I[uaf_pkg::TX_W-1:0] & wmask; // R21
            next_st.tx_par = uaf_pkg::parity_of(next_st.tx_sh,
                                                st.cfg.lcr.eps);
            next_st.tx_st = uaf_pkg::TX_START;
            next_st.tx_sc = '0;
          end else if (!tx_full) begin
            tx_we = 1'b1; // R01
          end
        end
        uaf_pkg::A_LCRH: begin
          next_st.cfg.lcr = WDATA_I[uaf_pkg::LCR_W-1:0]; // R07
        end
        uaf_pkg::A_IBRD: begin
          next_st.cfg.ibrd = WDATA_I[uaf_pkg::INT_W-1:0]; // R07
        end
        uaf_pkg::A_FBRD: begin
          next_st.cfg.fbrd = WDATA_I[uaf_pkg::FRAC_W-1:0]; // R07
        end
        uaf_pkg::A_CTRL: begin
          next_st.ctrl = WDATA_I[uaf_pkg::CTRL_W-1:0];
        end
        uaf_pkg::A_MASK: begin
          next_st.mask = WDATA_I[uaf_pkg::IRQ_W-1:0];
        end
        uaf_pkg::A_ECLR: begin
          ovr_clr = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered from flops next cycle
    next_st.rd_mem = 1'b0;
    next_st.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        uaf_pkg::A_DATA: begin
          if (!rx_empty) begin
            rx_re = 1'b1;
            next_st.rd_mem = 1'b1;
          end
        end
        uaf_pkg::A_STAT: next_st.rdata = uaf_pkg::DATA_W'(stat);
        uaf_pkg::A_LCRH: next_st.rdata = uaf_pkg::DATA_W'(st.cfg.lcr);
        uaf_pkg::A_IBRD: next_st.rdata = uaf_pkg::DATA_W'(st.cfg.ibrd);
        uaf_pkg::A_FBRD: next_st.rdata = uaf_pkg::DATA_W'(st.cfg.fbrd);
        uaf_pkg::A_CTRL: next_st.rdata = uaf_pkg::DATA_W'(st.ctrl);
        uaf_pkg::A_MASK: next_st.rdata = uaf_pkg::DATA_W'(st.mask);
        uaf_pkg::A_RIS: next_st.rdata = uaf_pkg::DATA_W'(raw);
        uaf_pkg::A_MIS: begin
          next_st.rdata = uaf_pkg::DATA_W'(raw & st.mask);
        end
        default: next_st.rdata = '0;
      endcase
    end

    // Transmit shifter
    if (st.tx_st != uaf_pkg::TX_IDLE && st.tx_st != uaf_pkg::TX_FETCH
        && tick) begin
      next_st.tx_sc = st.tx_sc + 1'b1;
    end
    case (st.tx_st)
      uaf_pkg::TX_IDLE: begin
        if (tx_on && !tx_empty) begin
          tx_re = 1'b1; // R11
          next_st.tx_st = uaf_pkg::TX_FETCH;
        end
      end
      uaf_pkg::TX_FETCH: begin
        next_st.tx_sh = tx_q & wmask;
        next_st.tx_par = uaf_pkg::parity_of(tx_q & wmask, st.cfg.lcr.eps);
        next_st.tx_st = uaf_pkg::TX_START;
        next_st.tx_sc = '0;
      end
      uaf_pkg::TX_START: begin
        if (bit_end) begin
          next_st.tx_st = uaf_pkg::TX_DATA;
          next_st.tx_bits = '0;
        end
      end
      uaf_pkg::TX_DATA: begin
        if (bit_end) begin
          next_st.tx_sh = st.tx_sh >> 1;
          next_st.tx_bits = st.tx_bits + 1'b1;
          if (st.tx_bits == uaf_pkg::last_bit(st.cfg.lcr.wlen)) begin
            next_st.tx_st = st.cfg.lcr.pen ? uaf_pkg::TX_PAR
                                           : uaf_pkg::TX_STOP; // R23
            next_st.tx_bits = '0;
          end
        end
      end
      uaf_pkg::TX_PAR: begin
        if (bit_end) begin
          next_st.tx_st = uaf_pkg::TX_STOP;
          next_st.tx_bits = '0;
        end
      end
      uaf_pkg::TX_STOP: begin
        if (bit_end) begin
          if (st.cfg.lcr.stp2 && st.tx_bits == '0) begin
            next_st.tx_bits = 3'h1; // R23
          end else begin
            next_st.tx_st = uaf_pkg::TX_IDLE;
          end
        end
      end
      default: next_st.tx_st = uaf_pkg::TX_IDLE;
    endcase
    case (next_st.tx_st)
      uaf_pkg::TX_START: next_st.tx_out = 1'b0; // R04
      uaf_pkg::TX_DATA: next_st.tx_out = next_st.tx_sh[0]; // R04
      uaf_pkg::TX_PAR: next_st.tx_out = next_st.tx_par; // R04
      default: next_st.tx_out = 1'b1;
    endcase
    if (next_st.cfg.lcr.brk) begin
      next_st.tx_out = 1'b0;
    end

    // Receiver
    if (!rx_on) begin
      next_st.rx_st = uaf_pkg::RX_IDLE;
      next_st.rx_armed = 1'b0;
    end else begin
      if (st.rx_st != uaf_pkg::RX_IDLE && tick) begin
        next_st.rx_sc = st.rx_sc + 1'b1;
        if (st.rx_sc == uaf_pkg::SMP_A) begin
          next_st.rx_sa = rx_line;
          next_st.rx_have = 1'b1;
        end
        if (st.rx_sc == uaf_pkg::SMP_B) begin
          next_st.rx_sb = rx_line;
        end
        if (decide) begin
          next_st.rx_have = 1'b0;
          next_st.rx_zero = st.rx_zero & ~maj;
        end
      end
      case (st.rx_st)
        uaf_pkg::RX_IDLE: begin
          if (rx_line) begin
            next_st.rx_armed = 1'b1;
          end
          if (tick && st.rx_armed && !rx_line) begin
            next_st.rx_st = uaf_pkg::RX_START;
            next_st.rx_sc = '0;
          end
        end
        uaf_pkg::RX_START: begin
          if (tick && st.rx_sc == uaf_pkg::SMP_B) begin
            if (rx_line) begin
              next_st.rx_st = uaf_pkg::RX_IDLE; // R14
            end else begin
              next_st.rx_st = uaf_pkg::RX_DATA;
              next_st.rx_have = 1'b0;
              next_st.rx_bits = '0;
              next_st.rx_sh = '0;
              next_st.rx_zero = 1'b1;
              next_st.rx_pe = 1'b0;
            end
          end
        end
        uaf_pkg::RX_DATA: begin
          if (decide) begin
            next_st.rx_sh = st.rx_sh
                | (uaf_pkg::TX_W'(maj) << st.rx_bits); // R15
            next_st.rx_bits = st.rx_bits + 1'b1;
            if (st.rx_bits == uaf_pkg::last_bit(st.cfg.lcr.wlen)) begin
              next_st.rx_st = st.cfg.lcr.pen ? uaf_pkg::RX_PAR
                                             : uaf_pkg::RX_STOP; // R15
            end
          end
        end
        uaf_pkg::RX_PAR: begin
          if (decide) begin
            next_st.rx_pe = maj != uaf_pkg::parity_of(st.rx_sh,
                                                      st.cfg.lcr.eps);
            next_st.rx_st = uaf_pkg::RX_STOP;
          end
        end
        uaf_pkg::RX_STOP: begin
          if (decide) begin
            rx_done = 1'b1; // R16
            next_st.rx_st = uaf_pkg::RX_IDLE;
            next_st.rx_armed = 1'b0;
          end
        end
        default: next_st.rx_st = uaf_pkg::RX_IDLE;
      endcase
    end

    // Store the character or flag overrun
    rx_wdata.data = st.rx_sh;
    rx_wdata.fe = !maj; // R16 R17
    rx_wdata.pe = st.rx_pe; // R17
    rx_wdata.brk = st.rx_zero & ~maj; // R17
    rx_wdata.ovr = st.overrun; // R19
    if (rx_done) begin
      if (rx_full && !rx_re) begin
        ovr_set = 1'b1; // R18 R20
      end else begin
        rx_we = 1'b1;
      end
    end
    // Set wins over a same-cycle clear
    next_st.overrun = ovr_set | (st.overrun & ~(rx_we | ovr_clr)); // R19

    // Queue bookkeeping
    if (tx_we) begin
      next_st.tx_wp = st.tx_wp + 1'b1;
    end
    if (tx_re) begin
      next_st.tx_rp = st.tx_rp + 1'b1;
    end
    next_st.tx_cnt = st.tx_cnt + CW'(tx_we) - CW'(tx_re);
    if (rx_we) begin
      next_st.rx_wp = st.rx_wp + 1'b1;
    end
    if (rx_re) begin
      next_st.rx_rp = st.rx_rp + 1'b1;
    end
    next_st.rx_cnt = st.rx_cnt + CW'(rx_we) - CW'(rx_re);
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st <= '0; // R24
      st.ctrl <= uaf_pkg::CTRL_RST;
      st.tx_out <= 1'b1; // R24
      st.sync1 <= 1'b1;
      st.sync2 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA_O = st.rd_mem ? uaf_pkg::DATA_W'(rx_q) : st.rdata;
  assign SERIAL_OUT_O = st.tx_out;
  assign BUSY_O = busy;
  assign IRQ_O = |(raw & st.mask); // R05

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_busy_while_sending: assert property ( // R12
    (st.tx_cnt != '0 || st.tx_st != uaf_pkg::TX_IDLE) |-> BUSY_O)
    else $error("busy low with data pending");
  a_start_bit_low: assert property ( // R04
    (st.tx_st == uaf_pkg::TX_START && !st.cfg.lcr.brk) |-> !SERIAL_OUT_O)
    else $error("start bit not low");
  a_stop_bit_high: assert property ( // R04
    (st.tx_st == uaf_pkg::TX_STOP && !st.cfg.lcr.brk) |-> SERIAL_OUT_O)
    else $error("stop bit not high");
  a_queue_cap: assert property ( // R03
    (st.rx_cnt <= cap) && (st.tx_cnt <= cap))
    else $error("queue count above capacity");
  a_overrun_full: assert property ( // R18
    (rx_done && rx_full && !rx_re) |=> (st.overrun &&
      st.rx_cnt == $past(st.rx_cnt)))
    else $error("overrun not raised or queue changed");
  a_overrun_copied: assert property ( // R19
    (rx_we && st.overrun) |=> (!st.overrun || $past(ovr_set)))
    else $error("overrun not cleared after store");
  a_irq_overrun: assert property ( // R05
    (st.overrun && st.mask[uaf_pkg::IRQ_OVR]) |-> IRQ_O)
    else $error("enabled overrun request not on output");
  a_false_start: assert property ( // R14
    (rx_on && st.rx_st == uaf_pkg::RX_START && tick &&
      st.rx_sc == uaf_pkg::SMP_B && rx_line)
      |=> st.rx_st == uaf_pkg::RX_IDLE)
    else $error("false start not dropped");
  a_tick_spacing: assert property ( // R10
    (tick && st.cfg.ibrd > 16'h0001 && $stable(st.cfg.ibrd)) |=> !tick)
    else $error("oversample ticks too close");
  a_tx_bit_len: assert property ( // R10
    (st.tx_st == uaf_pkg::TX_START && bit_end)
      |=> st.tx_st == uaf_pkg::TX_DATA)
    else $error("start bit did not end after 16 ticks");
endmodule
`default_nettype wire

// *** uaf_pkg.sv ***
// Purpose: Shared constants, types and helpers of the queued serial core
// Assumes: Byte addresses on an 8-bit register port, 32-bit data
// Notes: Queue depth must be a power of two
`default_nettype none
package uaf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TX_W = 8;
  localparam int RX_W = 12;
  localparam int Q_DEPTH = 32;
  localparam int INT_W = 16;
  localparam int FRAC_W = 6;
  localparam int CFG_W = 30;
  localparam int LCR_W = 8;
  localparam int CTRL_W = 4;
  localparam int IRQ_W = 3;
  localparam int STAT_W = 6;
  localparam int SC_W = 4;

  localparam logic [ADDR_W-1:0] A_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] A_LCRH = 8'h08;
  localparam logic [ADDR_W-1:0] A_IBRD = 8'h0C;
  localparam logic [ADDR_W-1:0] A_FBRD = 8'h10;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] A_RIS = 8'h1C;
  localparam logic [ADDR_W-1:0] A_MIS = 8'h20;
  localparam logic [ADDR_W-1:0] A_ECLR = 8'h24;

  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVR = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_RXE = 1;
  localparam int ST_RXF = 2;
  localparam int ST_TXE = 3;
  localparam int ST_TXF = 4;
  localparam int ST_OVR = 5;

  localparam logic [CTRL_W-1:0] CTRL_RST = 4'hC;
  localparam logic [SC_W-1:0] TICK_LAST = 4'hF;
  localparam logic [SC_W-1:0] SMP_A = 4'h6;
  localparam logic [SC_W-1:0] SMP_B = 4'h7;
  localparam logic [SC_W-1:0] SMP_C = 4'h8;
  localparam logic [2:0] LAST_BASE = 3'h4;

  typedef struct packed {
    logic spare;
    logic [1:0] wlen;
    logic fen;
    logic stp2;
    logic eps;
    logic pen;
    logic brk;
  } uaf_lcr_t;

  typedef struct packed {
    logic rxe;
    logic txe;
    logic loopback_enable;
    logic en;
  } uaf_ctrl_t;

  typedef struct packed {
    uaf_lcr_t lcr;
    logic [INT_W-1:0] ibrd;
    logic [FRAC_W-1:0] fbrd;
  } uaf_cfg_t;

  typedef struct packed {
    logic ovr;
    logic brk;
    logic pe;
    logic fe;
    logic [TX_W-1:0] data;
  } uaf_rx_entry_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_FETCH = 3'b001,
    TX_START = 3'b010,
    TX_DATA = 3'b011,
    TX_PAR = 3'b100,
    TX_STOP = 3'b101
  } uaf_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } uaf_rx_state_t;

  function automatic logic [TX_W-1:0] word_mask(input logic [1:0] wlen);
    case (wlen)
      2'h0: word_mask = 8'h1F;
      2'h1: word_mask = 8'h3F;
      2'h2: word_mask = 8'h7F;
      default: word_mask = 8'hFF;
    endcase
  endfunction

  function automatic logic [2:0] last_bit(input logic [1:0] wlen);
    last_bit = LAST_BASE + {1'b0, wlen};
  endfunction

  function automatic logic parity_of(input logic [TX_W-1:0] d,
                                     input logic eps);
    parity_of = (^d) ^ ~eps;
  endfunction
endpackage
`default_nettype wire

// *** uaf_mem.sv ***
// Purpose: Simple dual-port queue storage with registered read data
// Assumes: One write and one read port on the same clock
// Notes: Contents are not reset; flags live in the owner
`timescale 1ns/1ps
`default_nettype none
module uaf_mem #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  // Read port
  input wire logic re_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] q;
  } uaf_mem_state_t;

  uaf_mem_state_t st;
  uaf_mem_state_t next_st;

  always_comb begin
    next_st = st;
    if (we_i) begin
      next_st.mem[waddr_i] = wdata_i;
    end
    if (re_i) begin
      next_st.q = st.mem[raddr_i];
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign rdata_o = st.q;
endmodule
`default_nettype wire

// *** uaf_baud.sv ***
// Purpose: Fractional divider making the 16x oversampling tick
// Assumes: Divisor in 1/64 steps, integer part of zero stops ticks
// Notes: Period is int cycles, or int+1 after a fraction carry
`timescale 1ns/1ps
`default_nettype none
module uaf_baud (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Divisor
  input wire logic en_i,
  input wire logic [uaf_pkg::INT_W-1:0] int_i,
  input wire logic [uaf_pkg::FRAC_W-1:0] frac_i,
  // Tick
  output logic tick_o
);
  typedef struct packed {
    logic [uaf_pkg::INT_W:0] cnt;
    logic [uaf_pkg::FRAC_W-1:0] acc;
    logic extra;
    logic tick;
  } uaf_baud_state_t;

  uaf_baud_state_t st;
  uaf_baud_state_t next_st;
  logic [uaf_pkg::INT_W:0] limit;
  logic [uaf_pkg::FRAC_W:0] sum;

  always_comb begin
    next_st = st;
    limit = {1'b0, int_i} + {{uaf_pkg::INT_W{1'b0}}, st.extra};
    sum = {1'b0, st.acc} + {1'b0, frac_i};
    next_st.tick = 1'b0;
    if (!en_i || int_i == '0) begin
      next_st.cnt = '0;
    end else if (st.cnt + 1'b1 >= limit) begin
      // Carry out of the fraction stretches the next period
      next_st.cnt = '0;
      next_st.tick = 1'b1;
      next_st.acc = sum[uaf_pkg::FRAC_W-1:0];
      next_st.extra = sum[uaf_pkg::FRAC_W];
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
endmodule
`default_nettype wire

// *** uaf_peer.sv ***
// Purpose: Remote serial device model
// Assumes: One bit lasts BIT clock cycles, 8 data bits, no parity
// Notes: Line idles high as with a pull-up
`timescale 1ns/1ps
`default_nettype none
module uaf_peer #(
  parameter int BIT = 32
) (
  // Clock
  input wire logic clk_i,
  // Serial line
  input wire logic rx_i,
  output logic tx_o
);
  initial tx_o = 1'b1;
  // Stop level selectable to force a framing error
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      tx_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    tx_o <= 1'b1;
    repeat (BIT) @(posedge clk_i);
  endtask
  // Mid-bit sampling; ok is start low and stop high
  task automatic grab(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    while (rx_i !== 1'b0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    repeat (BIT / 2) @(posedge clk_i);
    // A start that never came fails the frame
    ok = (n < 400) && (rx_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      d[i] = rx_i;
    end
    repeat (BIT) @(posedge clk_i);
    ok = ok & (rx_i === 1'b1);
  endtask
  // Short low pulse a receiver must reject, then a long idle
  task automatic glitch(input int len);
    @(posedge clk_i);
    tx_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    tx_o <= 1'b1;
    repeat (12 * BIT) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Register-level bench of the queued serial core
// Assumes: Divisor 2 gives 32 cycles per bit
// Notes: Peer model drives the serial input
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, wr, rd, sin, sout, busy, irq, ok;
  logic [7:0] addr, b;
  logic [31:0] wdata, rdata;
  int error_cnt, samples_checked;
  uaf_core DUT (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SERIAL_IN_I(sin),
    .SERIAL_OUT_O(sout), .BUSY_O(busy), .IRQ_O(irq));
  uaf_peer u_peer (.clk_i(clk), .rx_i(sout), .tx_o(sin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      final_report();
    end
  endtask
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({31'h0, sout}, 32'h1);
    rchk(uaf_pkg::A_CTRL, 32'hC);
    rchk(uaf_pkg::A_STAT, 32'h0A);
    rchk(8'h80, 32'h0);
    $display("reset test done");
    wr_reg(uaf_pkg::A_IBRD, 32'h2);
    wr_reg(uaf_pkg::A_LCRH, 32'h70);
    wr_reg(uaf_pkg::A_CTRL, 32'hD);
    wr_reg(uaf_pkg::A_DATA, 32'hA5);
    chk({31'h0, busy}, 32'h1);
    u_peer.grab(b, ok);
    chk({23'h0, ok, b}, 32'h1A5);
    wait_idle(400);
    $display("transmit test done");
    u_peer.send(8'h3C, 1'b1);
    rchk(uaf_pkg::A_DATA, 32'h03C);
    u_peer.send(8'h81, 1'b0);
    rchk(uaf_pkg::A_DATA, 32'h181);
    u_peer.glitch(8);
    rchk(uaf_pkg::A_STAT, 32'h0A);
    $display("receive test done");
    wr_reg(uaf_pkg::A_LCRH, 32'h60);
    u_peer.send(8'h11, 1'b1);
    u_peer.send(8'h22, 1'b1);
    rchk(uaf_pkg::A_DATA, 32'h011);
    rchk(uaf_pkg::A_STAT, 32'h2A);
    u_peer.send(8'h33, 1'b1);
    wr_reg(uaf_pkg::A_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr_reg(uaf_pkg::A_MASK, 32'h4);
    chk({31'h0, irq}, 32'h0);
    rchk(uaf_pkg::A_DATA, 32'h833);
    $display("overrun test done");
    wr_reg(uaf_pkg::A_CTRL, 32'hF);
    wr_reg(uaf_pkg::A_DATA, 32'h5A);
    wait_idle(400);
    rchk(uaf_pkg::A_DATA, 32'h05A);
    wr_reg(uaf_pkg::A_LCRH, 32'h0E);
    rchk(uaf_pkg::A_LCRH, 32'h0E);
    wr_reg(uaf_pkg::A_DATA, 32'h35);
    wait_idle(400);
    rchk(uaf_pkg::A_DATA, 32'h015);
    $display("loopback test done");
    wr_reg(uaf_pkg::A_CTRL, 32'hC);
    wr_reg(uaf_pkg::A_LCRH, 32'h70);
    for (int i = 0; i < 33; i++) begin
      wr_reg(uaf_pkg::A_DATA, i);
    end
    rchk(uaf_pkg::A_STAT, 32'h13);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rchk(uaf_pkg::A_STAT, 32'h0A);
    $display("queue test done");
    final_report();
  end
endmodule
`default_nettype wire
